/* eea_pkg.sv */
package eea_pkg;

	// Density option: 6 (smallest) up to 10 (largest) word address bits
	localparam int WORD_AW   = 10;
	localparam int BYTE_AW   = WORD_AW + 1;
	localparam int MEM_WORDS = 1 << WORD_AW;

	// Instruction fields
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] OP_EXT   = 2'h0;

	localparam logic [1:0] EXT_LOCK   = 2'h0;
	localparam logic [1:0] EXT_FILL   = 2'h1;
	localparam logic [1:0] EXT_CLEAR  = 2'h2;
	localparam logic [1:0] EXT_UNLOCK = 2'h3;

	// Serial field lengths in link clock edges
	localparam logic [4:0] HDR_LEN16 = 5'(2 + WORD_AW);
	localparam logic [4:0] HDR_LEN8  = 5'(2 + BYTE_AW);
	localparam logic [4:0] DAT_LEN16 = 5'h10;
	localparam logic [4:0] DAT_LEN8  = 5'h08;

	// Reset and erased values
	localparam logic [15:0] ERASED_WORD   = 16'hffff;
	localparam logic        RST_WR_ENABLE = 1'b0;

	// Timing
	localparam int CLK_NS    = 25;
	localparam int T_PROG_NS = 4000000;
	localparam int PROG_CYC  = T_PROG_NS / CLK_NS;

	// Pin vector positions
	localparam int PIN_SEL = 0;
	localparam int PIN_SCK = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_ORG = 3;
	localparam int PIN_POR = 4;
	localparam int PIN_N   = 5;

	typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DATA, ST_READ, ST_WAIT} eea_state_t;
	typedef enum logic [2:0] {PK_NONE, PK_WRITE, PK_ERASE, PK_CLEAR, PK_FILL} eea_prog_t;

endpackage

/* eea_serial_eeprom.sv */
// Operation
// RULE1: Width pin high selects 16-bit words, low selects 8-bit bytes.
// RULE2: Array holds 1024 words or 2048 bytes at the largest density option.
// RULE3: Read loads received address, then shifts that location out serially.
// RULE4: After each location, address increments and output continues while selected.
// RULE5: Sequential read past the top address wraps to zero.
// RULE6: Programming is self-timed on the system clock, independent of link clock.
// RULE7: Write overwrites the location without a prior erase.
// RULE8: One write programs exactly one byte or one word.
// RULE9: After programming starts, data-out shows busy or ready while selected.
// RULE10: Data-out is released while not selected.
// RULE11: Master selects at most one memory at a time.
// RULE12: Instructions are ignored until power-on reset releases.
// RULE13: Power-on release leaves the device idle, deselected, no operation.
// RULE14: Power-on reset reasserting stops all instruction response.
// RULE15: Master keeps device deselected and idle during power-down.
// RULE16: Master holds select low while power is applied.
// RULE17: Seven instructions: read, write, enable, lock, erase, bulk clear, bulk fill.
// RULE18: Select rises with link clock low; first 1 on a rising edge starts.
// RULE19: Op-codes 10 read, 01 write, 11 erase, 00 extended by address bits.
// RULE20: Read gives one dummy 0 then data MSB first, none between locations.
// RULE21: Address is 10 bits in word mode, 11 bits in byte mode.
// RULE22: Select falling mid-instruction discards it and waits for a new start bit.
module eea_serial_eeprom
	import eea_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC
) (
	input  wire logic clk_sys,   // System clock, 40 MHz
	input  wire logic rst_n,     // Synchronous reset, active low
	input  wire logic sel_pin,   // Chip select, active high
	input  wire logic sclk_pin,  // Serial link clock
	input  wire logic sdi_pin,   // Serial data in
	input  wire logic org_pin,   // Width select, high for word mode
	input  wire logic por_n_pin, // Power-on reset, low holds device inhibited
	output logic      sdo_out,   // Serial data out level
	output logic      sdo_oe_n   // Serial data out enable, active low
);

	function automatic logic [WORD_AW-1:0] word_index(input logic [BYTE_AW-1:0] a, input logic x16);
		word_index = x16 ? a[WORD_AW-1:0] : a[BYTE_AW-1:1]; // RULE2
	endfunction

	function automatic logic [15:0] align_read(input logic [15:0] w, input logic [BYTE_AW-1:0] a,
	                                           input logic x16);
		if (x16) begin
			align_read = w;
		end else if (a[0]) begin
			align_read = {w[15:8], 8'h00};
		end else begin
			align_read = {w[7:0], 8'h00};
		end
	endfunction

	function automatic logic [BYTE_AW-1:0] wrap_inc(input logic [BYTE_AW-1:0] a, input logic x16);
		logic [BYTE_AW-1:0] n;
		n = a + 1'b1;
		if (x16) begin
			n[BYTE_AW-1] = 1'b0; // RULE5
		end
		wrap_inc = n;
	endfunction

	logic [PIN_N-1:0]   pin_m_r;
	logic [PIN_N-1:0]   pin_s_r;
	logic               sck_d_r;
	logic               sel_d_r;
	logic               sel_s;
	logic               sdi_s;
	logic               por_ok;
	logic               sck_rise;
	logic               sel_fall;
	eea_state_t         state_r;
	logic [4:0]         cnt_r;
	logic               x16_r;
	logic [BYTE_AW:0]   hdr_r;
	logic [BYTE_AW+1:0] hdr_full;
	logic [1:0]         hdr_op;
	logic [BYTE_AW-1:0] hdr_addr;
	logic [1:0]         hdr_ext;
	logic [4:0]         hdr_len;
	logic [4:0]         dat_len;
	logic [BYTE_AW-1:0] addr_r;
	logic [BYTE_AW-1:0] addr_nxt;
	logic [BYTE_AW-1:0] rd_addr;
	logic [15:0]        dat_r;
	logic [15:0]        dsh_r;
	logic               dout_r;
	eea_prog_t          pend_r;
	logic               wen_r;
	logic               armed_r;
	logic               status_r;
	logic               busy_r;
	eea_prog_t          kind_r;
	logic [31:0]        prog_cnt_r;
	logic [WORD_AW:0]   walk_r;
	logic [BYTE_AW-1:0] paddr_r;
	logic [15:0]        pdata_r;
	logic               px16_r;
	logic               prog_start;
	logic [15:0]        mem [MEM_WORDS];
	logic               mem_we;
	logic [WORD_AW-1:0] mem_wa;
	logic [15:0]        mem_wd;
	logic [1:0]         mem_be;

	// Two-stage sampling of every pin, plus edge history
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_m_r <= '0;
			pin_s_r <= '0;
			sck_d_r <= 1'b0;
			sel_d_r <= 1'b0;
		end else begin
			pin_m_r <= {por_n_pin, org_pin, sdi_pin, sclk_pin, sel_pin};
			pin_s_r <= pin_m_r;
			sck_d_r <= pin_s_r[PIN_SCK];
			sel_d_r <= pin_s_r[PIN_SEL];
		end
	end

	assign por_ok   = pin_s_r[PIN_POR];
	assign sel_s    = pin_s_r[PIN_SEL] & por_ok; // RULE12 RULE14
	assign sdi_s    = pin_s_r[PIN_SDI];
	assign sck_rise = pin_s_r[PIN_SCK] & ~sck_d_r;
	assign sel_fall = ~pin_s_r[PIN_SEL] & sel_d_r;

	assign hdr_full = {hdr_r, sdi_s};
	assign hdr_op   = x16_r ? hdr_full[WORD_AW+1:WORD_AW] : hdr_full[BYTE_AW+1:BYTE_AW]; // RULE19
	assign hdr_addr = x16_r ? {1'b0, hdr_full[WORD_AW-1:0]} : hdr_full[BYTE_AW-1:0]; // RULE21
	assign hdr_ext  = hdr_addr[(x16_r ? WORD_AW : BYTE_AW) - 1 -: 2];
	assign hdr_len  = x16_r ? HDR_LEN16 : HDR_LEN8; // RULE21
	assign dat_len  = x16_r ? DAT_LEN16 : DAT_LEN8; // RULE8
	assign addr_nxt = wrap_inc(addr_r, x16_r); // RULE5
	assign rd_addr  = (state_r == ST_HDR) ? hdr_addr : addr_nxt;

	// A frame may only open with the link clock low
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			armed_r <= 1'b0;
		end else if (!sel_s) begin
			armed_r <= 1'b0; // RULE13
		end else if (sel_s && !sel_d_r) begin
			armed_r <= ~pin_s_r[PIN_SCK]; // RULE18
		end
	end

	// Instruction receiver and read shifter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			x16_r   <= 1'b1;
			hdr_r   <= '0;
			addr_r  <= '0;
			dat_r   <= '0;
			dsh_r   <= '0;
			dout_r  <= 1'b0;
			pend_r  <= PK_NONE;
			wen_r   <= RST_WR_ENABLE;
		end else if (!por_ok) begin
			state_r <= ST_IDLE; // RULE14
			pend_r  <= PK_NONE;
			wen_r   <= RST_WR_ENABLE;
		end else if (!sel_s) begin
			state_r <= ST_IDLE; // RULE22
			cnt_r   <= '0;
			pend_r  <= PK_NONE;
		end else if (sck_rise) begin
			unique case (state_r)
				ST_IDLE: begin
					if (armed_r && sdi_s && !busy_r) begin
						state_r <= ST_HDR; // RULE18
						cnt_r   <= '0;
						hdr_r   <= '0;
						x16_r   <= pin_s_r[PIN_ORG]; // RULE1
					end
				end
				ST_HDR: begin
					hdr_r <= hdr_full[BYTE_AW:0];
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == hdr_len - 5'h01) begin
						cnt_r  <= '0;
						addr_r <= hdr_addr;
						unique case (hdr_op) // RULE17
							OP_READ: begin
								state_r <= ST_READ; // RULE3
								dout_r  <= 1'b0; // RULE20
								dsh_r   <= align_read(mem[word_index(rd_addr, x16_r)], rd_addr, x16_r);
							end
							OP_WRITE: begin
								state_r <= ST_DATA;
								pend_r  <= PK_WRITE; // RULE7
							end
							OP_ERASE: begin
								state_r <= ST_WAIT;
								pend_r  <= PK_ERASE;
							end
							OP_EXT: begin
								unique case (hdr_ext)
									EXT_LOCK: begin
										state_r <= ST_WAIT;
										wen_r   <= 1'b0;
									end
									EXT_UNLOCK: begin
										state_r <= ST_WAIT;
										wen_r   <= 1'b1;
									end
									EXT_CLEAR: begin
										state_r <= ST_WAIT;
										pend_r  <= PK_CLEAR;
									end
									EXT_FILL: begin
										state_r <= ST_DATA;
										pend_r  <= PK_FILL;
									end
								endcase
							end
						endcase
					end
				end
				ST_DATA: begin
					dat_r <= {dat_r[14:0], sdi_s};
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == dat_len - 5'h01) begin
						state_r <= ST_WAIT; // RULE8
					end
				end
				ST_READ: begin
					dout_r <= dsh_r[15]; // RULE20
					dsh_r  <= {dsh_r[14:0], 1'b0};
					cnt_r  <= cnt_r + 5'h01;
					if (cnt_r == dat_len - 5'h01) begin
						cnt_r  <= '0;
						addr_r <= addr_nxt; // RULE4
						dsh_r  <= align_read(mem[word_index(rd_addr, x16_r)], rd_addr, x16_r);
					end
				end
				ST_WAIT: begin
				end
			endcase
		end
	end

	assign prog_start = sel_fall && por_ok && (state_r == ST_WAIT) && (pend_r != PK_NONE) && wen_r && !busy_r;

	// Self-timed programming engine, runs only on the system clock
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_r     <= 1'b0;
			kind_r     <= PK_NONE;
			prog_cnt_r <= '0;
			walk_r     <= '0;
			paddr_r    <= '0;
			pdata_r    <= '0;
			px16_r     <= 1'b1;
		end else if (prog_start) begin
			busy_r     <= 1'b1; // RULE6
			kind_r     <= pend_r;
			prog_cnt_r <= '0;
			walk_r     <= '0;
			paddr_r    <= addr_r;
			pdata_r    <= dat_r;
			px16_r     <= x16_r;
		end else if (busy_r) begin
			prog_cnt_r <= prog_cnt_r + 32'h1;
			if (!walk_r[WORD_AW]) begin
				walk_r <= walk_r + 1'b1;
			end
			// Bulk ops also hold busy until every word has been walked
			if (prog_cnt_r >= 32'(PROG_CYCLES - 1) &&
			    (walk_r[WORD_AW] || kind_r == PK_WRITE || kind_r == PK_ERASE)) begin
				busy_r <= 1'b0; // RULE6
				kind_r <= PK_NONE;
			end
		end
	end

	// Array write port: single location on the first cycle, bulk ops walk every word
	always_comb begin
		mem_we = 1'b0;
		mem_wa = word_index(paddr_r, px16_r);
		mem_wd = px16_r ? pdata_r : {pdata_r[7:0], pdata_r[7:0]};
		mem_be = px16_r ? 2'h3 : (paddr_r[0] ? 2'h2 : 2'h1); // RULE8
		if (busy_r) begin
			unique case (kind_r)
				PK_WRITE: begin
					mem_we = (prog_cnt_r == 32'h0); // RULE7
				end
				PK_ERASE: begin
					mem_we = (prog_cnt_r == 32'h0);
					mem_wd = ERASED_WORD;
				end
				PK_CLEAR: begin
					mem_we = ~walk_r[WORD_AW];
					mem_wa = walk_r[WORD_AW-1:0];
					mem_wd = ERASED_WORD;
					mem_be = 2'h3;
				end
				PK_FILL: begin
					mem_we = ~walk_r[WORD_AW];
					mem_wa = walk_r[WORD_AW-1:0];
					mem_be = 2'h3;
				end
				PK_NONE: begin
				end
			endcase
		end
	end

	// One process owns the array; byte lanes are gated inside it
	always_ff @(posedge clk_sys) begin
		for (int g = 0; g < 2; g++) begin
			if (mem_we && mem_be[g]) begin
				mem[mem_wa][g*8 +: 8] <= mem_wd[g*8 +: 8];
			end
		end
	end

	// Busy/ready status is offered from programming start until the next start bit
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !por_ok) begin
			status_r <= 1'b0;
		end else if (prog_start) begin
			status_r <= 1'b1; // RULE9
		end else if (state_r == ST_HDR) begin
			status_r <= 1'b0;
		end
	end

	// Output pin driver
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sdo_out  <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else begin
			sdo_oe_n <= ~(sel_s && ((state_r == ST_READ) || ((state_r == ST_IDLE) && status_r))); // RULE10
			sdo_out  <= (state_r == ST_READ) ? dout_r : ~busy_r; // RULE9
		end
	end

endmodule

/* eea_serial_eeprom_assertions.sv */
module eea_serial_eeprom_chk
	import eea_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC
) (
	input wire logic clk_sys,   // Clock
	input wire logic rst_n,     // Reset
	input wire logic sel_pin,   // Select
	input wire logic sclk_pin,  // Link clock
	input wire logic sdi_pin,   // Data in
	input wire logic org_pin,   // Width
	input wire logic por_n_pin, // Power-on
	input wire logic sdo_out,   // Data out
	input wire logic sdo_oe_n   // Out enable
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] low_cnt_r;
	// Length of the current stretch in which the device drives the line low while selected
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !sel_pin || sdo_oe_n || sdo_out) begin
			low_cnt_r <= '0;
		end else begin
			low_cnt_r <= low_cnt_r + 32'h1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Drive starts just after a link clock rise: a read, not a status poll
	sequence s_read;
		$fell(sdo_oe_n) && $past(sclk_pin, 3);
	endsequence
	sequence s_busy;
		sel_pin && !sdo_oe_n && !sdo_out;
	endsequence
	property p_rst;
		disable iff (1'b0) !rst_n |=> sdo_oe_n && !sdo_out;
	endproperty
	property p_rel;
		!sel_pin [*6] |-> sdo_oe_n;
	endproperty
	property p_por;
		!por_n_pin [*5] |-> sdo_oe_n;
	endproperty
	property p_zero;
		s_read |-> !sdo_out;
	endproperty
	property p_fsel;
		$fell(sdo_oe_n) |-> sel_pin && por_n_pin;
	endproperty
	property p_rise;
		$rose(sdo_oe_n) |-> !sel_pin || !por_n_pin || !$past(rst_n) || $past(sclk_pin, 2);
	endproperty
	property p_sel;
		$rose(sel_pin) |-> sdo_oe_n [*2];
	endproperty
	property p_ready;
		s_busy |-> low_cnt_r < 32'(PROG_CYCLES + MEM_WORDS + 16);
	endproperty
	a_rst: assert property (p_rst) else $error("out not idle in reset");
	a_rel: assert property (p_rel) else $error("out driven while deselected");
	a_por: assert property (p_por) else $error("out driven under power-on reset");
	a_zero: assert property (p_zero) else $error("first driven bit not zero");
	a_fsel: assert property (p_fsel) else $error("drive began unselected");
	a_rise: assert property (p_rise) else $error("release without cause");
	a_sel: assert property (p_sel) else $error("drive at select rise");
	a_ready: assert property (p_ready) else $error("never ready");
endmodule

bind eea_serial_eeprom eea_serial_eeprom_chk #(.PROG_CYCLES(PROG_CYCLES)) i_eea_serial_eeprom_chk (.clk_sys(clk_sys),
	.rst_n(rst_n),
	.sel_pin(sel_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .org_pin(org_pin), .por_n_pin(por_n_pin),
	.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));

/* eea_bus_master.sv */
module eea_bus_master (
	input  wire logic clk_sys,  // Clock
	input  wire logic sdo_out,  // Device data
	input  wire logic sdo_oe_n, // Device enable
	output logic      sel_pin,  // Select
	output logic      sclk_pin, // Link clock
	output logic      sdi_pin,  // Data out
	output logic      drove     // Device drove this frame
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_r;
	logic line;
	// Released line toggles so a stale level is never read
	assign line = sdo_oe_n ? ~last_r : sdo_out;
	initial begin
		sel_pin = 1'b0;
		sclk_pin = 1'b0;
		sdi_pin = 1'b0;
		drove = 1'b0;
		last_r = 1'b0;
	end
	always @(posedge clk_sys) begin
		last_r <= line;
		if (!sdo_oe_n) drove <= 1'b1;
	end
	task automatic frame(input logic [63:0] v, input int n, output logic [63:0] q);
		q = '0;
		drove <= 1'b0;
		sel_pin <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_pin <= v[i];
			repeat (4) @(posedge clk_sys);
			q = {q[62:0], line};
			sclk_pin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			sclk_pin <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		q = {q[62:0], line};
		sel_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic poll(output logic busy, output int w);
		sel_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		// A released line is no status: only a driven low counts as busy
		busy = !sdo_oe_n && !line;
		w = 0;
		while (!sdo_oe_n && line !== 1'b1 && w < 4000) begin
			@(posedge clk_sys);
			w++;
		end
		sel_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule

/* eea_serial_eeprom_tb_top.sv */
module eea_serial_eeprom_tb_top import eea_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        org_pin = 1'b1;
	logic        por_n_pin = 1'b1;
	logic        sel_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe_n, drove;
	logic [63:0] q;
	int          num_errors = 0;
	int          checks_done = 0;
	localparam logic [12:0] UNLOCK = {1'b1, OP_EXT, EXT_UNLOCK, 8'h00};
	// Longer than a bulk walk of the whole array
	localparam int PROG_T = 1200;
	always #12.5 clk_sys = ~clk_sys;
	eea_serial_eeprom #(.PROG_CYCLES(PROG_T)) i_eea_serial_eeprom (.clk_sys(clk_sys), .rst_n(rst_n),
		.sel_pin(sel_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .org_pin(org_pin), .por_n_pin(por_n_pin),
		.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
	eea_bus_master i_eea_bus_master (.clk_sys(clk_sys), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
		.sel_pin(sel_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .drove(drove));
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic go(input logic [63:0] v, input int n);
		i_eea_bus_master.frame(v, n, q);
	endtask
	task automatic rd(input logic [9:0] a, input int nw);
		go(64'({1'b1, OP_READ, a}) << (16 * nw), 13 + 16 * nw);
	endtask
	// Frame, then poll until ready; b tells whether programming must run
	task automatic prog(input logic [63:0] v, input int n, input logic b);
		logic busy;
		int   w;
		go(v, n);
		i_eea_bus_master.poll(busy, w);
		chk(64'(busy), 64'(b));
		chk(64'(drove), 64'(b));
		chk(64'(b ? (w > PROG_T - 20 && w < PROG_T) : (w == 0)), 64'h1);
	endtask
	task automatic t_word();
		go(64'(UNLOCK), 13);
		prog(64'({1'b1, OP_WRITE, 10'h3ff, 16'h1234}), 29, 1'b1);
		prog(64'({1'b1, OP_WRITE, 10'h000, 16'habcd}), 29, 1'b1);
		prog(64'({1'b1, OP_WRITE, 10'h3ff, 16'h5a5a}), 29, 1'b1);
		rd(10'h3ff, 2);
		chk(64'(q[32:0]), 64'h5a5a_abcd);
		prog(64'({1'b1, OP_ERASE, 10'h000}), 13, 1'b1);
		rd(10'h3ff, 2);
		chk(64'(q[32:0]), 64'({16'h5a5a, ERASED_WORD}));
	endtask
	task automatic t_byte();
		org_pin <= 1'b0;
		prog(64'({1'b1, OP_WRITE, 11'h7ff, 8'h3c}), 22, 1'b1);
		go(64'({1'b1, OP_READ, 11'h7fe}) << 24, 38);
		chk(64'(q[24:0]), 64'h5a3cff);
		org_pin <= 1'b1;
		rd(10'h3ff, 1);
		chk(64'(q[16:0]), 64'h3c5a);
	endtask
	task automatic t_lock();
		go(64'({1'b1, OP_EXT, EXT_LOCK, 8'h00}), 13);
		prog(64'({1'b1, OP_WRITE, 10'h000, 16'h1111}), 29, 1'b0);
		go(64'(UNLOCK), 13);
		prog(64'({1'b1, OP_WRITE, 10'h000, 8'h11}), 21, 1'b0);
		rd(10'h000, 1);
		chk(64'(q[16:0]), 64'(ERASED_WORD));
	endtask
	task automatic t_bulk();
		prog(64'({1'b1, OP_EXT, EXT_FILL, 8'h00, 16'hc33c}), 29, 1'b1);
		rd(10'h3ff, 2);
		chk(64'(q[32:0]), 64'hc33c_c33c);
		prog(64'({1'b1, OP_EXT, EXT_CLEAR, 8'h00}), 13, 1'b1);
		rd(10'h3ff, 2);
		chk(64'(q[32:0]), 64'hffff_ffff);
	endtask
	task automatic t_por();
		por_n_pin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(10'h3ff, 1);
		chk(64'(drove), 64'h0);
		por_n_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(10'h3ff, 1);
		chk(64'(q[16:0]), 64'hffff);
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(64'(sdo_oe_n), 64'h1);
		t_word();
		t_byte();
		t_lock();
		t_bulk();
		t_por();
		wrap_up();
	end
endmodule
